/* File: rtl/rtc_alarm_ctrl.sv */
`timescale 1ns/10ps
`include "rtc_alarm_consts.svh"

module rtc_alarm_ctrl #(
  parameter int unsigned  IRQ_PULSE_CYCLES = `IRQ_PULSE_CYC,
  // Identifier default is arbitrary
  parameter logic [63:0]  FACTORY_ID       = 64'h0123_4567_89ab_cdef
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        xfer_stop,
  output logic      [7:0]  reg_rdata,
  input  wire logic        sr_read_active,
  input  wire logic        scl_in,
  input  wire logic        on_battery_in,
  input  wire logic        osc_in,
  input  wire logic        time_update,
  input  wire logic [7:0]  tod_sec,
  input  wire logic [7:0]  tod_min,
  input  wire logic [7:0]  tod_hour,
  input  wire logic [7:0]  tod_date,
  input  wire logic [7:0]  tod_month,
  input  wire logic [7:0]  tod_dow,
  input  wire logic        array_wr_req,
  input  wire logic [8:0]  array_wr_addr,
  output logic             array_wr_grant,
  input  wire logic        irq_pin_i,
  output logic             irq_pin_o,
  output logic             irq_pin_oe_n,
  output logic      [6:0]  cap_trim_half_pf,
  output logic      [6:0]  rate_trim_ppm,
  output logic             serial_bus_en,
  output logic             switchover_select,
  output logic             nv_commit
);

  localparam int PW = $clog2(IRQ_PULSE_CYCLES + 1);

  if (IRQ_PULSE_CYCLES < 1) begin : g_bad_pulse
    $error("IRQ_PULSE_CYCLES must be at least one");
  end

  // ==================================================
  // Decode helpers
  function automatic logic [7:0] field_mask(input logic [2:0] f);
    logic [7:0] m;
    m = 8'h00;
    unique case (f)
      `F_SEC:   m = `FM_SEC;
      `F_MIN:   m = `FM_MIN;
      `F_HOUR:  m = `FM_HOUR;
      `F_DATE:  m = `FM_DATE;
      `F_MONTH: m = `FM_MONTH;
      `F_YEAR:  m = 8'h00;
      `F_DOW:   m = `FM_DOW;
      `F_Y2K:   m = `FM_Y2K;
    endcase
    return m;
  endfunction

  // Disabled field always counts as a hit
  function automatic logic field_hit(input logic [7:0] a,
                                     input logic [7:0] t,
                                     input logic [2:0] f);
    return !a[7] || (((a ^ t) & field_mask(f) & 8'h7f) == 8'h00);
  endfunction

  function automatic logic is_locked(input logic [2:0] code,
                                     input logic [8:0] addr);
    logic l;
    l = 1'b0;
    unique case (code)
      3'd0: l = 1'b0;                     // RULE_06
      3'd1: l = addr >= `LOCK_QTR;        // RULE_06
      3'd2: l = addr >= `LOCK_HALF;       // RULE_06
      3'd3: l = 1'b1;                     // RULE_06
      3'd4: l = addr <= `LOCK_P4;         // RULE_07
      3'd5: l = addr <= `LOCK_P8;         // RULE_07
      3'd6: l = addr <= `LOCK_P16;        // RULE_07
      3'd7: l = 1'b1;                     // RULE_07
    endcase
    return l;
  endfunction

  // ==================================================
  // Synchronisers for pins
  logic        scl_meta;
  logic        scl_sync;
  logic        scl_prev;
  logic        bat_meta;
  logic        bat_sync;
  logic        osc_meta;
  logic        osc_sync;
  logic        osc_prev;

  always_ff @(posedge core_clk)
  begin
    scl_meta <= scl_in;
    scl_sync <= scl_meta;
    bat_meta <= on_battery_in;
    bat_sync <= bat_meta;
    osc_meta <= osc_in;
    osc_sync <= osc_meta;
    if (!rstn)
    begin
      scl_prev <= 1'b1;
      osc_prev <= 1'b0;
    end
    else
    begin
      scl_prev <= scl_sync;
      osc_prev <= osc_sync;
    end
  end

  wire scl_fall = scl_prev & ~scl_sync;
  wire osc_rise = osc_sync & ~osc_prev;

  // ==================================================
  // Register storage
  logic [7:0]  alarm_mem [0:15];
  logic [7:0]  lock_cfg;
  logic [7:0]  int_cfg;
  logic [7:0]  atr_cfg;
  logic [7:0]  dtr_cfg;
  logic [7:0]  pwr_cfg;
  logic        write_latch;
  logic        reg_write_latch;
  logic        ccr_written;
  logic [1:0]  alarm_flag;

  // Control writes only land with both latches set
  wire ccr_ok   = reg_wr & reg_write_latch;              // RULE_20
  wire alm_area = reg_addr[5:4] == 2'b00;
  wire ctl_area = reg_addr >= `ADDR_BL && reg_addr <= `ADDR_PWR;
  wire wr_alarm = ccr_ok & alm_area;
  wire wr_ctl   = ccr_ok & ctl_area;
  wire wr_sr    = reg_wr & (reg_addr == `ADDR_SR);
  wire [7:0] alm_wmask = field_mask(reg_addr[2:0]);     // RULE_01

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 16; i++)
        alarm_mem[i] <= (i[2:0] == `F_Y2K) ? `RST_Y2K : 8'h00;
      lock_cfg <= 8'h00;
      int_cfg  <= `RST_INT;                              // RULE_12
      atr_cfg  <= 8'h00;
      dtr_cfg  <= 8'h00;
      pwr_cfg  <= `RST_PWR;
    end
    else
    begin
      // Year bytes have no storage; mask is zero there
      if (wr_alarm)
        alarm_mem[reg_addr[3:0]] <= reg_wdata & alm_wmask; // RULE_02
      if (wr_ctl && reg_addr == `ADDR_BL)
        lock_cfg <= reg_wdata & `WM_BL;
      if (wr_ctl && reg_addr == `ADDR_INT)
        int_cfg <= reg_wdata & `WM_INT;
      if (wr_ctl && reg_addr == `ADDR_ATR)
        atr_cfg <= reg_wdata & `WM_ATR;
      if (wr_ctl && reg_addr == `ADDR_DTR)
        dtr_cfg <= reg_wdata & `WM_DTR;
      if (wr_ctl && reg_addr == `ADDR_PWR)
        pwr_cfg <= reg_wdata & `WM_PWR;
    end
  end

  // ==================================================
  // Write latches; register latch drops at end of write
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      write_latch     <= 1'b0;
      reg_write_latch <= 1'b0;
      ccr_written     <= 1'b0;
    end
    else
    begin
      if (wr_sr && reg_wdata == `SR_CLR)
      begin
        write_latch     <= 1'b0;
        reg_write_latch <= 1'b0;
      end
      else if (wr_sr && reg_wdata == `SR_WEL)
        write_latch <= 1'b1;
      else if (wr_sr && reg_wdata == `SR_REG_WRITE_LATCH && write_latch)
        reg_write_latch <= 1'b1;                         // RULE_20
      if (xfer_stop && ccr_written)
        reg_write_latch <= 1'b0;
      ccr_written <= xfer_stop ? 1'b0 : (ccr_written | wr_alarm | wr_ctl);
    end
  end

  // ==================================================
  // Alarm compare
  logic [1:0] any_en;
  logic [1:0] match;

  for (genvar k = 0; k < 2; k++) begin : g_alm
    localparam int B = k * 8;
    // Year byte left out of both lists
    assign any_en[k] = alarm_mem[B + 0][7] | alarm_mem[B + 1][7] |
                       alarm_mem[B + 2][7] | alarm_mem[B + 3][7] |
                       alarm_mem[B + 4][7] | alarm_mem[B + 6][7]; // RULE_02
    assign match[k] = any_en[k] &                              // RULE_25
      field_hit(alarm_mem[B + 0], tod_sec,   `F_SEC)   &        // RULE_04
      field_hit(alarm_mem[B + 1], tod_min,   `F_MIN)   &
      field_hit(alarm_mem[B + 2], tod_hour,  `F_HOUR)  &
      field_hit(alarm_mem[B + 3], tod_date,  `F_DATE)  &
      field_hit(alarm_mem[B + 4], tod_month, `F_MONTH) &
      field_hit(alarm_mem[B + 6], tod_dow,   `F_DOW);           // RULE_03
  end

  // Sampled only on the update strobe, so a held match fires once per strobe cycle
  wire [1:0] alarm_ev = {2{time_update}} & match;             // RULE_24

  // ==================================================
  // Status flags, cleared on eighth falling clock of a read
  logic [3:0] fall_cnt;
  wire sr_clear = sr_read_active & scl_fall & (fall_cnt == `SR_FALLS);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      fall_cnt   <= 4'h0;
      alarm_flag <= 2'b00;
    end
    else
    begin
      if (!sr_read_active)
        fall_cnt <= 4'h0;
      else if (scl_fall && fall_cnt <= `SR_FALLS)
        fall_cnt <= fall_cnt + 4'h1;
      // New event wins over a clear in the same cycle
      alarm_flag <= alarm_ev | (alarm_flag & {2{~sr_clear}}); // RULE_21
    end
  end

  // ==================================================
  // Shared pin: alarm interrupt, oscillator or divided clock
  wire pulsed_irq_mode   = int_cfg[7];
  wire alarm1_irq_enable = int_cfg[6];
  wire alarm0_irq_enable = int_cfg[5];
  wire any_irq_en        = alarm0_irq_enable | alarm1_irq_enable;
  rtc_alarm_pkg::pin_mode_type pin_mode;
  assign pin_mode = rtc_alarm_pkg::pin_mode_type'(int_cfg[4:3]); // RULE_10

  logic [14:0]   osc_div;
  logic [PW-1:0] pulse_cnt;

  // Alarm 0 takes priority when both are enabled
  wire pulse_src = alarm0_irq_enable ? alarm_ev[0]
                                     : alarm1_irq_enable & alarm_ev[1]; // RULE_23
  wire pulse_go  = pulsed_irq_mode & (pin_mode == rtc_alarm_pkg::pin_alarm)
                   & pulse_src;                                   // RULE_09
  wire single_low = (alarm_flag[0] & alarm0_irq_enable) |
                    (alarm_flag[1] & alarm1_irq_enable);          // RULE_22
  wire irq_active = any_irq_en &                                  // RULE_08
                    (pulsed_irq_mode ? (pulse_cnt != '0) : single_low);

  // 32k output follows the synchronised oscillator, one core clock (100 ns) late
  logic clk_level;
  always_comb
  begin
    clk_level = 1'b1;
    unique case (pin_mode)
      rtc_alarm_pkg::pin_alarm: clk_level = 1'b1;
      rtc_alarm_pkg::pin_32k:   clk_level = osc_sync;
      rtc_alarm_pkg::pin_4k:    clk_level = osc_div[`DIV_4K];
      rtc_alarm_pkg::pin_1hz:   clk_level = osc_div[`DIV_1HZ];
    endcase
  end

  // Any clock selection masks the interrupt
  wire next_oe_n = (pin_mode == rtc_alarm_pkg::pin_alarm)
                   ? ~irq_active : clk_level;                     // RULE_11

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      osc_div      <= 15'h0000;
      pulse_cnt    <= '0;
      irq_pin_o    <= 1'b0;
      irq_pin_oe_n <= 1'b1;
    end
    else
    begin
      if (osc_rise)
        osc_div <= osc_div + 15'h0001;
      if (pulse_go)
        pulse_cnt <= PW'(IRQ_PULSE_CYCLES);                       // RULE_09
      else if (pulse_cnt != '0)
        pulse_cnt <= pulse_cnt - PW'(1);
      irq_pin_o    <= 1'b0;
      irq_pin_oe_n <= next_oe_n;
    end
  end

  // ==================================================
  // Trim, power, array lock and read data
  wire [6:0] trim_mag = (dtr_cfg[1] ? `TRIM_10 : 7'd0) +
                        (dtr_cfg[0] ? `TRIM_20 : 7'd0);           // RULE_14
  wire [6:0] next_ppm = dtr_cfg[2] ? 7'd0 - trim_mag : trim_mag; // RULE_15
  wire [6:0] next_cap = 7'({~atr_cfg[5], atr_cfg[4:0]}) + `CAP_BASE; // RULE_13
  wire wr_locked = is_locked(lock_cfg[7:5], array_wr_addr);

  // Identifier bytes come from a parameter and have no write path
  wire [7:0] id_byte = FACTORY_ID[8 * reg_addr[2:0] +: 8];     // RULE_18
  wire [7:0] sr_byte = {bat_sync, alarm_flag[1], alarm_flag[0], 2'b00,
                        reg_write_latch, write_latch, 1'b0};
  wire [7:0] next_rdata =
    alm_area ? (reg_addr[2:0] == `F_YEAR ? 8'h00
                                         : alarm_mem[reg_addr[3:0]]) :
    reg_addr == `ADDR_BL  ? lock_cfg :
    reg_addr == `ADDR_INT ? int_cfg  :
    reg_addr == `ADDR_ATR ? atr_cfg  :
    reg_addr == `ADDR_DTR ? dtr_cfg  :
    reg_addr == `ADDR_PWR ? pwr_cfg  :
    reg_addr[5:3] == `ADDR_ID ? id_byte :
    reg_addr == `ADDR_SR  ? sr_byte  : 8'h00;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      reg_rdata         <= 8'h00;
      array_wr_grant    <= 1'b0;
      cap_trim_half_pf  <= 7'h00;
      rate_trim_ppm     <= 7'h00;
      serial_bus_en     <= 1'b1;
      switchover_select <= 1'b0;
      nv_commit         <= 1'b0;
    end
    else
    begin
      reg_rdata         <= next_rdata;
      array_wr_grant    <= array_wr_req & ~wr_locked;            // RULE_05
      cap_trim_half_pf  <= next_cap;
      rate_trim_ppm     <= next_ppm;
      serial_bus_en     <= ~(pwr_cfg[7] & bat_sync);             // RULE_16
      switchover_select <= pwr_cfg[6];                           // RULE_17
      nv_commit         <= wr_alarm | wr_ctl;                    // RULE_19
    end
  end

  // ==================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_flag_on_match;
    time_update && match[0] |=> alarm_flag[0];
  endproperty
  a_flag_on_match: assert property (p_flag_on_match) // RULE_21
    else $error("alarm 0 flag not set after match");

  property p_no_enable_no_match;
    !any_en[1] |=> !$rose(alarm_flag[1]);
  endproperty
  a_no_enable_no_match: assert property (p_no_enable_no_match) // RULE_25
    else $error("alarm 1 matched with no field enabled");

  property p_flag_only_on_update;
    $rose(alarm_flag[0]) |-> $past(time_update);
  endproperty
  a_flag_only_on_update: assert property (p_flag_only_on_update) // RULE_24
    else $error("alarm flag rose without time update");

  property p_flag_clear;
    sr_clear && !alarm_ev[1] |=> !alarm_flag[1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) // RULE_21
    else $error("alarm 1 flag survived status read");

  property p_lock_full;
    array_wr_req && (lock_cfg[6:5] == 2'b11) |=> !array_wr_grant;
  endproperty
  a_lock_full: assert property (p_lock_full) // RULE_06
    else $error("write granted with full array locked");

  property p_grant_cause;
    array_wr_grant |-> $past(array_wr_req) && !$past(wr_locked);
  endproperty
  a_grant_cause: assert property (p_grant_cause) // RULE_05
    else $error("array write granted without cause");

  property p_clock_masks_irq;
    pin_mode != rtc_alarm_pkg::pin_alarm && clk_level |=> irq_pin_oe_n;
  endproperty
  a_clock_masks_irq: assert property (p_clock_masks_irq) // RULE_11
    else $error("pin driven while clock level high");

  property p_single_hold;
    !pulsed_irq_mode && alarm_flag[0] && alarm0_irq_enable &&
    pin_mode == rtc_alarm_pkg::pin_alarm |=> !irq_pin_oe_n;
  endproperty
  a_single_hold: assert property (p_single_hold) // RULE_22
    else $error("pin released while alarm flag pending");

  property p_pulse_load;
    pulse_go |=> pulse_cnt == PW'(IRQ_PULSE_CYCLES);
  endproperty
  a_pulse_load: assert property (p_pulse_load) // RULE_09
    else $error("pulse not started on alarm match");

  property p_alarm0_priority;
    alarm0_irq_enable && alarm_ev[1] && !alarm_ev[0] |-> !pulse_go;
  endproperty
  a_alarm0_priority: assert property (p_alarm0_priority) // RULE_23
    else $error("alarm 1 pulsed while alarm 0 enabled");

  property p_reset_clkout;
    $past(!rstn) |-> pin_mode == rtc_alarm_pkg::pin_32k;
  endproperty
  a_reset_clkout: assert property (p_reset_clkout) // RULE_12
    else $error("output select not 32k after reset");

  property p_bus_off;
    pwr_cfg[7] && bat_sync |=> !serial_bus_en;
  endproperty
  a_bus_off: assert property (p_bus_off) // RULE_16
    else $error("serial bus left on in backup");

  c_pulse_start: cover property (pulse_go);
  c_flag_cleared: cover property (alarm_flag[0] ##1 sr_clear);
  c_write_refused: cover property (array_wr_req && wr_locked);
  c_both_alarms: cover property (alarm_ev == 2'b11);

endmodule // rtc_alarm_ctrl

/* File: rtl/rtc_alarm_consts.svh */
`ifndef RTC_ALARM_CONSTS_SVH
`define RTC_ALARM_CONSTS_SVH
// Operation
// RULE_01: Alarm byte mirrors time byte; MSB enables.
// RULE_02: No year compare in either alarm.
// RULE_03: Enabled fields all equal time: alarm event.
// RULE_04: Any subset of fields may be enabled.
// RULE_05: Writes to protected array locations are dropped.
// RULE_06: Codes 0-3: none, upper quarter, half, all.
// RULE_07: Codes 4-7: first 40h, 80h, 100h, all.
// RULE_08: Alarm irq needs an enable and select 00.
// RULE_09: Pulsed mode pulses pin on every match.
// RULE_10: Select: alarm, 32.768kHz, 4096Hz, 1Hz.
// RULE_11: Clock output selected suppresses alarm interrupt.
// RULE_12: Output select resets to 32.768kHz clock.
// RULE_13: Six-bit cap trim, bit 5 inverted weight.
// RULE_14: Rate trim steps of 10 and 20 ppm.
// RULE_15: Trim sign bit; zero magnitude means none.
// RULE_16: Bus off in backup when bit set.
// RULE_17: Switchover select: standard or legacy criterion.
// RULE_18: Eight read-only bytes hold 64-bit identifier.
// RULE_19: Settings kept in non-volatile storage.
// RULE_20: Host sets write latches before control writes.
// RULE_21: Match sets flag; eighth clock of read clears.
// RULE_22: Single mode holds pin low until flag read.
// RULE_23: Pulsed mode with both enables uses alarm 0.
// RULE_24: Compare once per time update only.
// RULE_25: Alarm with no field enabled never matches.

// ==================================================
// Register offsets
`define F_SEC      3'd0
`define F_MIN      3'd1
`define F_HOUR     3'd2
`define F_DATE     3'd3
`define F_MONTH    3'd4
`define F_YEAR     3'd5
`define F_DOW      3'd6
`define F_Y2K      3'd7
`define ADDR_BL    6'h10
`define ADDR_INT   6'h11
`define ADDR_ATR   6'h12
`define ADDR_DTR   6'h13
`define ADDR_PWR   6'h14
`define ADDR_ID    3'h4
`define ADDR_SR    6'h3f
// ==================================================
// Field layouts, bit 7 of alarm bytes is the enable
`define FM_SEC     8'hff
`define FM_MIN     8'hff
`define FM_HOUR    8'hbf
`define FM_DATE    8'hbf
`define FM_MONTH   8'h9f
`define FM_DOW     8'h87
`define FM_Y2K     8'h39
`define WM_BL      8'he0
`define WM_INT     8'hf8
`define WM_ATR     8'h3f
`define WM_DTR     8'h07
`define WM_PWR     8'hc0
`define SR_CLR     8'h00
`define SR_WEL     8'h02
`define SR_REG_WRITE_LATCH    8'h06
// ==================================================
// Reset values and timing
`define RST_INT    8'h08
`define RST_PWR    8'h40
`define RST_Y2K    8'h20
`define CAP_BASE   7'd18
`define TRIM_10    7'd10
`define TRIM_20    7'd20
`define LOCK_QTR   9'h180
`define LOCK_HALF  9'h100
`define LOCK_P4    9'h03f
`define LOCK_P8    9'h07f
`define LOCK_P16   9'h0ff
`define DIV_4K     2
`define DIV_1HZ    14
`define SR_FALLS   4'd7
`define IRQ_PULSE_US 1000
`define CORE_CLK_NS  100
`define IRQ_PULSE_CYC ((`IRQ_PULSE_US * 1000) / `CORE_CLK_NS)
`endif

/* File: rtl/rtc_alarm_pkg.sv */
package rtc_alarm_pkg;
  typedef enum logic [1:0] {
    pin_alarm,
    pin_32k,
    pin_4k,
    pin_1hz
  } pin_mode_type;
endpackage

/* File: dv/rtc_host_model.sv */
`timescale 1ns/10ps

// ====================================
// Host side of the register link
module rtc_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [5:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            xfer_stop,
  output logic            sr_read_active,
  output logic            scl_in
);
  initial
  begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    xfer_stop = 1'b0;
    sr_read_active = 1'b0;
    scl_in = 1'b1;
  end

  // ====================================
  // Bus tasks
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    xfer_stop <= 1'b1;
    @(posedge core_clk);
    xfer_stop <= 1'b0;
    // Released data must not keep looking valid
    reg_wdata <= ~d;
  endtask

  task automatic wr_ctrl(input logic [5:0] a, input logic [7:0] d);
    wr(6'h3f, 8'h02);
    wr(6'h3f, 8'h06);
    wr(a, d);
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    repeat (2) @(posedge core_clk);
    #1;
    d = reg_rdata;
  endtask

  // Eight clock falls of a status byte; line idles high on its pull-up
  task automatic sr_clear;
    @(posedge core_clk);
    sr_read_active <= 1'b1;
    repeat (8)
    begin
      repeat (4) @(posedge core_clk);
      scl_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      scl_in <= 1'b1;
    end
    repeat (4) @(posedge core_clk);
    sr_read_active <= 1'b0;
  endtask
endmodule // rtc_host_model

/* File: dv/rtc_alarm_and_control_regs_tb.sv */
`timescale 1ns/10ps

// ====================================
// Bench top
module rtc_alarm_and_control_regs_tb;
  localparam logic [63:0] ID = 64'h5a3c_0f96_1e2d_4b87; // Arbitrary value
  localparam logic [7:0]  PULSE = 8'h04;
  logic       core_clk;
  logic       rstn;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       xfer_stop;
  logic [7:0] reg_rdata;
  logic       sr_read_active;
  logic       scl_in;
  logic       on_battery_in;
  logic       osc_in;
  logic       time_update;
  logic [7:0] tod_sec;
  logic [7:0] tod_min;
  logic       array_wr_req;
  logic [8:0] array_wr_addr;
  logic       array_wr_grant;
  logic       irq_pin_o;
  logic       irq_pin_oe_n;
  logic       irq_level;
  logic [6:0] cap_trim_half_pf;
  logic [6:0] rate_trim_ppm;
  logic       serial_bus_en;
  logic       switchover_select;
  logic       nv_commit;
  logic [7:0] d;
  int         c;
  int         num_errors;
  int         check_count;
  int         nv_count = 0;

  // Pin is open drain with a pull-up
  assign irq_level = irq_pin_oe_n ? 1'b1 : irq_pin_o;

  // Counts accepted non-volatile bytes
  always @(posedge core_clk)
    if (nv_commit === 1'b1)
      nv_count <= nv_count + 1;

  rtc_alarm_ctrl #(.IRQ_PULSE_CYCLES(4), .FACTORY_ID(ID)) DUT (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .xfer_stop(xfer_stop),
    .reg_rdata(reg_rdata), .sr_read_active(sr_read_active),
    .scl_in(scl_in), .on_battery_in(on_battery_in), .osc_in(osc_in),
    .time_update(time_update), .tod_sec(tod_sec), .tod_min(tod_min),
    .tod_hour(8'h00), .tod_date(8'h00), .tod_month(8'h00),
    .tod_dow(8'h00), .array_wr_req(array_wr_req),
    .array_wr_addr(array_wr_addr), .array_wr_grant(array_wr_grant),
    .irq_pin_i(irq_level), .irq_pin_o(irq_pin_o),
    .irq_pin_oe_n(irq_pin_oe_n), .cap_trim_half_pf(cap_trim_half_pf),
    .rate_trim_ppm(rate_trim_ppm), .serial_bus_en(serial_bus_en),
    .switchover_select(switchover_select), .nv_commit(nv_commit));

  rtc_host_model host (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .xfer_stop(xfer_stop),
    .sr_read_active(sr_read_active), .scl_in(scl_in));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial
  begin
    osc_in = 1'b0;
    forever #15259 osc_in = ~osc_in;
  end

  // ====================================
  // Helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    host.rd(a, d);
    check(d, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic lows(input int n);
    c = 0;
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      if (irq_pin_oe_n === 1'b0)
        c++;
    end
  endtask

  task automatic upd(input logic [7:0] s, input logic [7:0] m);
    @(posedge core_clk);
    tod_sec <= s;
    tod_min <= m;
    time_update <= 1'b1;
    @(posedge core_clk);
    time_update <= 1'b0;
  endtask

  function automatic logic locked(input logic [2:0] k, input logic [8:0] x);
    case (k)
      3'h0: return 1'b0;
      3'h1: return x >= 9'h180;
      3'h2: return x >= 9'h100;
      3'h4: return x <= 9'h03f;
      3'h5: return x <= 9'h07f;
      3'h6: return x <= 9'h0ff;
      default: return 1'b1;
    endcase
  endfunction

  // ====================================
  // Scenarios
  task automatic t_reset;
    rdc(6'h11, 8'h08);
    rdc(6'h14, 8'h40);
    check({1'b0, cap_trim_half_pf}, 8'd50);
    check({1'b0, rate_trim_ppm}, 8'h00);
    check({7'h00, switchover_select}, 8'h01);
    lows(400);
    check({7'h00, c > 100 && c < 300}, 8'h01);
    $display("t_reset done");
  endtask

  task automatic t_access;
    host.wr(6'h11, 8'h00);
    rdc(6'h11, 8'h08);
    check(nv_count[7:0], 8'h00);
    host.wr_ctrl(6'h20, 8'hff);
    for (int i = 0; i < 8; i++)
      rdc(6'h20 + 6'(i), ID[8*i +: 8]);
    host.wr_ctrl(6'h05, 8'h33);
    rdc(6'h05, 8'h00);
    rdc(6'h3f, 8'h02);
    $display("t_access done");
  endtask

  task automatic t_lock;
    logic [8:0] a[10] = '{9'h000, 9'h03f, 9'h040, 9'h07f, 9'h080,
                          9'h0ff, 9'h100, 9'h17f, 9'h180, 9'h1ff};
    for (int k = 0; k < 8; k++)
    begin
      host.wr_ctrl(6'h10, {k[2:0], 5'h00});
      rdc(6'h10, {k[2:0], 5'h00});
      for (int i = 0; i < 10; i++)
      begin
        @(posedge core_clk);
        array_wr_req <= 1'b1;
        array_wr_addr <= a[i];
        @(posedge core_clk);
        array_wr_req <= 1'b0;
        #1;
        check({7'h00, array_wr_grant}, {7'h00, !locked(k, a[i])});
      end
    end
    $display("t_lock done");
  endtask

  task automatic t_trim;
    logic [6:0] m;
    for (int i = 0; i < 64; i++)
    begin
      host.wr_ctrl(6'h12, i[7:0]);
      tick(1);
      check({1'b0, cap_trim_half_pf}, {2'b0, ~i[5], i[4:0]} + 8'd18);
    end
    for (int i = 0; i < 8; i++)
    begin
      host.wr_ctrl(6'h13, i[7:0]);
      tick(1);
      m = (i[1] ? 7'd10 : 7'd0) + (i[0] ? 7'd20 : 7'd0);
      check({1'b0, rate_trim_ppm}, {1'b0, i[2] ? ~m + 7'd1 : m});
    end
    $display("t_trim done");
  endtask

  task automatic t_power;
    c = nv_count;
    host.wr_ctrl(6'h14, 8'h80);
    tick(1);
    check(nv_count[7:0] - c[7:0], 8'h01);
    @(posedge core_clk);
    on_battery_in <= 1'b1;
    tick(6);
    check({7'h00, serial_bus_en}, 8'h00);
    check({7'h00, switchover_select}, 8'h00);
    @(posedge core_clk);
    on_battery_in <= 1'b0;
    host.wr_ctrl(6'h14, 8'h00);
    @(posedge core_clk);
    on_battery_in <= 1'b1;
    tick(6);
    check({7'h00, serial_bus_en}, 8'h01);
    @(posedge core_clk);
    on_battery_in <= 1'b0;
    $display("t_power done");
  endtask

  task automatic t_single;
    host.wr_ctrl(6'h00, 8'hb0);
    host.wr_ctrl(6'h01, 8'h85);
    host.wr_ctrl(6'h11, 8'h20);
    upd(8'h00, 8'h00);
    tick(3);
    rdc(6'h3f, 8'h02);
    upd(8'h30, 8'h00);
    tick(3);
    rdc(6'h3f, 8'h02);
    upd(8'h30, 8'h05);
    tick(3);
    rdc(6'h3f, 8'h22);
    tick(20);
    check({7'h00, irq_pin_oe_n}, 8'h00);
    check({7'h00, irq_pin_o}, 8'h00);
    host.sr_clear;
    tick(4);
    check({7'h00, irq_pin_oe_n}, 8'h01);
    rdc(6'h3f, 8'h02);
    $display("t_single done");
  endtask

  task automatic t_pulse;
    host.wr_ctrl(6'h01, 8'h00);
    host.wr_ctrl(6'h09, 8'h85);
    host.wr_ctrl(6'h11, 8'he0);
    upd(8'h00, 8'h05);
    lows(12);
    check(c[7:0], 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      upd(8'h30, 8'h00);
      lows(12);
      check(c[7:0], PULSE);
    end
    host.sr_clear;
    $display("t_pulse done");
  endtask

  task automatic t_clkout;
    host.wr_ctrl(6'h11, 8'h28);
    upd(8'h30, 8'h00);
    lows(400);
    check({7'h00, c > 100 && c < 300}, 8'h01);
    rdc(6'h3f, 8'h22);
    host.wr_ctrl(6'h11, 8'h30);
    lows(2600);
    check({7'h00, c > 1000 && c < 1600}, 8'h01);
    host.wr_ctrl(6'h11, 8'h18);
    lows(2600);
    check({7'h00, c == 2600}, 8'h01);
    $display("t_clkout done");
  endtask

  initial
  begin
    num_errors = 0;
    check_count = 0;
    rstn = 1'b0;
    on_battery_in = 1'b0;
    time_update = 1'b0;
    tod_sec = 8'h00;
    tod_min = 8'h00;
    array_wr_req = 1'b0;
    array_wr_addr = 9'h000;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    tick(2);
    t_reset;
    t_access;
    t_lock;
    t_trim;
    t_power;
    t_single;
    t_pulse;
    t_clkout;
    conclude;
  end

  // Whole run is a few thousand cycles
  initial
  begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    $display("FAIL t=%0t watchdog expired", $time);
    conclude;
  end
endmodule // rtc_alarm_and_control_regs_tb
